// [sdt_map.svh]
// offsets, field positions, reset values and timing counts of the discard timer block
`ifndef SDT_MAP_SVH
`define SDT_MAP_SVH
`define SDT_BRIDGE_EXT_CTRL_OFF 8'h3e
`define SDT_BRIDGE_EXT_CTRL_RST 16'h0000
`define SDT_RESERVED_UPPER_NIBBLE_HI 15
`define SDT_RESERVED_UPPER_NIBBLE_LO 12
`define SDT_ERR_EN_BIT 11
`define SDT_FLAG_BIT 10
`define SDT_SEL_BIT 9
`define SDT_PRI_BIT 8
`define SDT_LONG_EXP 15
`define SDT_SHORT_EXP 10
`define SDT_CNT_W 16
`define SDT_LONG_CYC 16'h8000
`define SDT_SHORT_CYC 16'h0400
`endif

// [sdt_pkg.sv]
// types shared by the discard timer block
package sdt_pkg;
  typedef enum logic [1:0]
  {
    SDT_IDLE,
    SDT_COUNT,
    SDT_EXPIRE
  } sdt_state_t;
  typedef enum logic
  {
    SDT_SEV_NONFATAL,
    SDT_SEV_FATAL
  } sdt_sev_t;
endpackage : sdt_pkg

// [sdt_counter.sv]
// discard timeout counter with selectable length
`include "sdt_map.svh"
module sdt_counter
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pci_tick_i,
  input wire logic run_i,
  input wire logic short_sel_i,
  output logic expired_o
);
  import sdt_pkg::*;
  logic [`SDT_CNT_W-1:0] cnt_r;
  logic [`SDT_CNT_W-1:0] cnt_nxt;
  logic [`SDT_CNT_W-1:0] limit;
  ////////////////////////////////////////////////////////////////////////
  // count pci clocks while running; clearing when idle restarts each wait
  always_comb
  begin
    limit = short_sel_i ? `SDT_SHORT_CYC : `SDT_LONG_CYC; // R6
    cnt_nxt = cnt_r;
    if (!run_i)
    begin
      cnt_nxt = '0; // R11
    end
    else if (pci_tick_i && cnt_r < limit)
    begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end
  // a mid-wait shortening takes effect at once since compare is >=
  assign expired_o = run_i && (cnt_r >= limit);
endmodule : sdt_counter

// [sdt_discard_timer.sv]
// bridge extension control upper byte and secondary discard timer
// Operation
// R1 - bits 15:12 reserved, read zero, writes ignored.
// R2 - enable bit set and timer expiry discards: send error message upstream; here sent only while conv_pci_mode_i is set.
// R3 - message severity nonfatal by default; fatal only with advanced reporting.
// R4 - enable clear: message only via advanced reporting with mask bit clear.
// R5 - expiry sets status flag; reads zero otherwise; software clears it.
// R6 - select bit zero gives 2^15 pci clocks, one gives 2^10.
// R7 - counter starts once delayed completion reaches downstream queue head.
// R8 - expiry before repeat deletes the delayed transaction and sets flag.
// R9 - secondary master repeats identical request before timeout or loses data.
// R10 - primary discard timer bit hardwired zero, ignores writes.
// R11 - repeat and delivery stops and resets counter; next completion restarts it.
`include "sdt_map.svh"
module sdt_discard_timer
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pci_tick_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [1:0] cfg_be_i,
  input wire logic [15:0] cfg_wdata_i,
  output logic [15:0] cfg_rdata_o,
  input wire logic head_valid_i,
  input wire logic repeat_done_i,
  input wire logic conv_pci_mode_i,
  input wire logic aer_present_i,
  input wire logic aer_mask_i,
  input wire sdt_pkg::sdt_sev_t aer_sev_i,
  output logic discard_o,
  output logic err_msg_o,
  output sdt_pkg::sdt_sev_t err_sev_o
);
  import sdt_pkg::*;
  logic err_en_r;
  logic err_en_nxt;
  logic flag_r;
  logic flag_nxt;
  logic sel_r;
  logic sel_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  sdt_state_t state_r;
  sdt_state_t state_nxt;
  logic discard_r;
  logic discard_nxt;
  logic msg_r;
  logic msg_nxt;
  sdt_sev_t sev_r;
  sdt_sev_t sev_nxt;
  logic expired;
  logic hit;
  logic [15:0] reg_view;
  ////////////////////////////////////////////////////////////////////////
  // register view; reserved nibble and primary bit stay zero
  assign hit = (cfg_addr_i == `SDT_BRIDGE_EXT_CTRL_OFF);
  always_comb
  begin
    reg_view = 16'h0000; // R1 R10
    reg_view[`SDT_ERR_EN_BIT] = err_en_r;
    reg_view[`SDT_FLAG_BIT] = flag_r;
    reg_view[`SDT_SEL_BIT] = sel_r;
  end
  ////////////////////////////////////////////////////////////////////////
  // register writes and read data; only the upper byte lane matters here
  always_comb
  begin
    err_en_nxt = err_en_r;
    sel_nxt = sel_r;
    flag_nxt = flag_r;
    rdata_nxt = 16'h0000;
    if (hit && cfg_rd_i)
    begin
      rdata_nxt = reg_view;
    end
    if (hit && cfg_wr_i && cfg_be_i[1])
    begin
      err_en_nxt = cfg_wdata_i[`SDT_ERR_EN_BIT];
      sel_nxt = cfg_wdata_i[`SDT_SEL_BIT];
      if (cfg_wdata_i[`SDT_FLAG_BIT])
      begin
        flag_nxt = 1'b0; // R5
      end
    end
    // set wins over a clear in the same cycle so no discard is lost
    if (state_r == SDT_EXPIRE)
    begin
      flag_nxt = 1'b1; // R5 R8
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      err_en_r <= 1'b0;
      sel_r <= 1'b0; // R6
      flag_r <= 1'b0;
      rdata_r <= `SDT_BRIDGE_EXT_CTRL_RST;
    end
    else
    begin
      err_en_r <= err_en_nxt;
      sel_r <= sel_nxt;
      flag_r <= flag_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign cfg_rdata_o = rdata_r;
  ////////////////////////////////////////////////////////////////////////
  // wait for the initiator to repeat; counter only runs in SDT_COUNT
  sdt_counter i_sdt_counter
  (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pci_tick_i(pci_tick_i),
    .run_i(state_r == SDT_COUNT),
    .short_sel_i(sel_r),
    .expired_o(expired)
  );
  always_comb
  begin
    state_nxt = state_r;
    discard_nxt = 1'b0;
    msg_nxt = 1'b0;
    sev_nxt = sev_r;
    case (state_r)
      SDT_IDLE:
      begin
        if (head_valid_i)
        begin
          state_nxt = SDT_COUNT; // R7
        end
      end
      SDT_COUNT:
      begin
        // a repeat in the expiry cycle still delivers: the data is in hand
        if (repeat_done_i)
        begin
          state_nxt = SDT_IDLE; // R11
        end
        else if (expired)
        begin
          state_nxt = SDT_EXPIRE; // R8
        end
      end
      SDT_EXPIRE:
      begin
        discard_nxt = 1'b1; // R8
        state_nxt = SDT_IDLE;
        if (conv_pci_mode_i && (err_en_r || (aer_present_i && !aer_mask_i)))
        begin
          msg_nxt = 1'b1; // R2 R4
        end
        sev_nxt = aer_present_i ? aer_sev_i : SDT_SEV_NONFATAL; // R3
      end
      default:
      begin
        state_nxt = SDT_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= SDT_IDLE;
      discard_r <= 1'b0;
      msg_r <= 1'b0;
      sev_r <= SDT_SEV_NONFATAL;
    end
    else
    begin
      state_r <= state_nxt;
      discard_r <= discard_nxt;
      msg_r <= msg_nxt;
      sev_r <= sev_nxt;
    end
  end
  assign discard_o = discard_r;
  assign err_msg_o = msg_r;
  assign err_sev_o = sev_r;
  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_reserved_upper_nibble_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(hit && cfg_rd_i) |-> cfg_rdata_o[15:12] == 4'h0 && !cfg_rdata_o[8]) // R1
    else $error("reserved or primary bit read nonzero");
  // watch the pin itself so a leak through the read mux shows up at any time
  chk_pri_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cfg_rdata_o[`SDT_PRI_BIT]) // R10
    else $error("primary timer bit not zero");
  chk_msg_enabled: assert property (@(posedge clk_i) disable iff (!nrst_i)
    discard_o && $past(err_en_r) && $past(conv_pci_mode_i) |-> err_msg_o) // R2
    else $error("enabled discard sent no message");
  chk_msg_gated: assert property (@(posedge clk_i) disable iff (!nrst_i)
    err_msg_o |-> discard_o && $past(err_en_r || (aer_present_i && !aer_mask_i))) // R4
    else $error("message without enable");
  chk_sev_default: assert property (@(posedge clk_i) disable iff (!nrst_i)
    discard_o && !$past(aer_present_i) |-> err_sev_o == SDT_SEV_NONFATAL) // R3
    else $error("fatal severity without advanced reporting");
  chk_flag_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
    discard_o |-> flag_r) // R5
    else $error("discard without status flag");
  chk_start_head: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_r == SDT_IDLE && !head_valid_i |=> state_r != SDT_COUNT) // R7
    else $error("counter started without completion at head");
  chk_short_len: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(state_r == SDT_COUNT) && sel_r && pci_tick_i && !repeat_done_i
    ##1 (pci_tick_i && sel_r && !repeat_done_i)[*8] |-> !discard_o) // R6
    else $error("short timeout fired too early");
  chk_repeat_stop: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_r == SDT_COUNT && repeat_done_i |=> state_r == SDT_IDLE ##1 !discard_o) // R11
    else $error("repeat did not stop the timer");
  chk_expire_drop: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_r == SDT_COUNT && expired && !repeat_done_i |-> ##2 discard_o) // R8
    else $error("expiry did not discard");
  cov_discard: cover property (@(posedge clk_i) disable iff (!nrst_i) discard_o);
  cov_msg: cover property (@(posedge clk_i) disable iff (!nrst_i) err_msg_o);
  cov_repeat: cover property (@(posedge clk_i) disable iff (!nrst_i)
    state_r == SDT_COUNT && repeat_done_i);
endmodule : sdt_discard_timer

// [sdt_sec_master.sv]
// secondary bus master model that repeats a delayed request after a set wait
module sdt_sec_master
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic head_valid_i,
  input wire logic en_i,
  input wire logic [15:0] wait_i,
  output logic repeat_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_r;
  ////////////////////////////////////////////////////////////////////////////////
  // one repeat per completion; a wait beyond the timeout models a slow master
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_r <= 16'h0000;
      repeat_done_o <= 1'b0;
    end
    else
    begin
      repeat_done_o <= en_i && head_valid_i && (cnt_r == wait_i);
      cnt_r <= head_valid_i ? cnt_r + 16'h0001 : 16'h0000;
    end
  end
endmodule : sdt_sec_master

// [secondary_discard_timer_ctrl_tb.sv]
// self-checking bench for the discard timer block
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module secondary_discard_timer_ctrl_tb import sdt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, head_valid = 1'b0, repeat_done;
  logic conv = 1'b1, aer_present = 1'b0, aer_mask = 1'b0, slave_en = 1'b0;
  logic discard, err_msg;
  logic tick = 1'b1, half = 1'b0;
  logic [1:0] be = 2'b10;
  logic [7:0] addr = 8'h3e;
  logic [15:0] wdata = 16'h0000, rdata, rv;
  sdt_sev_t sev_in = SDT_SEV_FATAL, err_sev;
  int fail_count = 0, tests_run = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  // pci tick every cycle, or every other cycle to prove the count follows the enable
  always @(negedge clk) tick <= half ? ~tick : 1'b1;
  sdt_discard_timer i_sdt_discard_timer (.clk_i(clk), .nrst_i(nrst), .pci_tick_i(tick),
    .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata),
    .cfg_rdata_o(rdata), .head_valid_i(head_valid), .repeat_done_i(repeat_done),
    .conv_pci_mode_i(conv), .aer_present_i(aer_present), .aer_mask_i(aer_mask),
    .aer_sev_i(sev_in), .discard_o(discard), .err_msg_o(err_msg), .err_sev_o(err_sev));
  // the master answers just before the 1024-tick timeout, so a stale count would show
  sdt_sec_master i_sdt_sec_master (.clk_i(clk), .nrst_i(nrst), .head_valid_i(head_valid),
    .en_i(slave_en), .wait_i(16'd1000), .repeat_done_o(repeat_done));
  ////////////////////////////////////////////////////////////////////////////////
  // config accesses: one strobe cycle, then one idle cycle so that two calls in a
  // row never drop and raise the same strobe in one time step
  task automatic cfg_write(input logic [15:0] d);
    wr = 1'b1;
    addr = 8'h3e;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : cfg_write
  // read data stands for the one cycle after the taking edge
  task automatic cfg_read(input logic [7:0] a, output logic [15:0] d);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
    @(negedge clk);
  endtask : cfg_read
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // present a completion at the queue head and wait for discard or repeat
  task automatic run_timer(input logic exp_d, input logic exp_e, input sdt_sev_t exp_sev,
    input int lo);
    int n;
    n = 0;
    head_valid = 1'b1;
    @(negedge clk);
    while (discard !== 1'b1 && repeat_done !== 1'b1 && n < lo + 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= lo + 200)
    begin
      fail_count++;
      $display("mismatch at %0t: timer wait ran out", $time);
      wrap_up();
    end
    `CHK(discard, exp_d)
    `CHK(err_msg, exp_e)
    if (exp_d) `CHK(n >= lo && n <= lo + 6, 1'b1)
    if (exp_e) `CHK(err_sev, exp_sev)
    head_valid = 1'b0;
    repeat (4) @(negedge clk);
  endtask : run_timer
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    cfg_read(8'h3e, rv);
    `CHK(rv, 16'h0000)
    cfg_write(16'hffff);
    cfg_read(8'h3e, rv);
    `CHK(rv, 16'h0a00)
    cfg_read(8'h3c, rv);
    `CHK(rv, 16'h0000)
    run_timer(1'b1, 1'b1, SDT_SEV_NONFATAL, 1024);
    cfg_read(8'h3e, rv);
    `CHK(rv, 16'h0e00)
    cfg_write(16'h0600);
    cfg_read(8'h3e, rv);
    `CHK(rv, 16'h0200)
    be = 2'b01;
    cfg_write(16'h0000);
    be = 2'b10;
    cfg_read(8'h3e, rv);
    `CHK(rv, 16'h0200)
    aer_present = 1'b1;
    run_timer(1'b1, 1'b1, SDT_SEV_FATAL, 1024);
    aer_mask = 1'b1;
    run_timer(1'b1, 1'b0, SDT_SEV_NONFATAL, 1024);
    cfg_write(16'h0a00);
    conv = 1'b0;
    run_timer(1'b1, 1'b0, SDT_SEV_NONFATAL, 1024);
    half = 1'b1;
    run_timer(1'b1, 1'b0, SDT_SEV_NONFATAL, 2048);
    half = 1'b0;
    conv = 1'b1;
    slave_en = 1'b1;
    run_timer(1'b0, 1'b0, SDT_SEV_NONFATAL, 1024);
    run_timer(1'b0, 1'b0, SDT_SEV_NONFATAL, 1024);
    slave_en = 1'b0;
    cfg_write(16'h0000);
    run_timer(1'b1, 1'b0, SDT_SEV_NONFATAL, 32768);
    wrap_up();
  end
endmodule : secondary_discard_timer_ctrl_tb
